// >>> logic/bsw_pkg.sv
// Constants shared by the stopwatch timer files
// Operation
// - Hundredths and tenths BCD digits are each readable at their own address.
// - Digit registers are read-only; all eight counter bits clear at reset.
// - Writing one to the clear bit zeroes both digits; zero does nothing.
// - A clear while running keeps counting from zero at once.
// - A clear while stopped holds zero until counting is restarted.
// - The clear bit is write-only and always reads zero.
// - Run bit starts and stops counting, reads back, resets to zero.
// - Stopped holds the value; resuming counts on from the held value.
// - Two readable interrupt enables, 10 Hz and 1 Hz, reset to zero.
// - Flag register: bit 0 is the 10 Hz event, bit 1 the 1 Hz event.
// - Event flags set on overflow regardless of the enable bits.
// - Flags clear only on a written one; zero after reset.
// - Interrupt request stands while flag and enable are both set.
// - All bits above bit 1 of control, enable and flag registers read zero.
// - 10 Hz and 1 Hz events fire when low and high digits wrap 9 to 0.
// - Low digit steps every two or three 256 Hz ticks; decade 25 or 26.
// - Tenths decades of 25 and 26 ticks mix four to six, 256 per second.
package bsw_pkg;

    // ======================================================================
    // Register indices; byte address is four times the index
    localparam logic [15:0] BSW_IDX_CONTROL   = 16'hFF7C;
    localparam logic [15:0] BSW_IDX_HUNDREDTH = 16'hFF7D;
    localparam logic [15:0] BSW_IDX_TENTH     = 16'hFF7E;
    localparam logic [15:0] BSW_IDX_IRQ_EN    = 16'hFFE7;
    localparam logic [15:0] BSW_IDX_IRQ_FLAG  = 16'hFFF7;
    localparam int          BSW_ADDR_W        = 18;

    // ======================================================================
    // Field positions
    localparam int BSW_BIT_RUN   = 0;
    localparam int BSW_BIT_CLEAR = 1;
    localparam int BSW_BIT_TENTH = 0;
    localparam int BSW_BIT_ONE   = 1;

    // ======================================================================
    // Reset values
    localparam logic [3:0] BSW_DIGIT_RESET = 4'h0;
    localparam logic       BSW_RUN_RESET   = 1'b0;
    localparam logic [1:0] BSW_EN_RESET    = 2'h0;
    localparam logic [1:0] BSW_FLAG_RESET  = 2'h0;

    // ======================================================================
    // Count pattern
    localparam logic [3:0] BSW_DIGIT_MAX   = 4'h9;
    localparam logic [1:0] BSW_SHORT_STEP  = 2'h2;
    localparam logic [1:0] BSW_LONG_STEP   = 2'h3;
    localparam logic [3:0] BSW_EXTRA_DIGIT = 4'h8;
    // Tenths values 1,3,5,6,8,9 get a 26-tick decade, the rest 25
    localparam logic [9:0] BSW_LONG_DECADE = 10'h36A;

endpackage : bsw_pkg

// >>> logic/bsw_pacer.sv
// Step pacer: turns 256 Hz ticks into 2- or 3-tick digit steps
`timescale 1ns/1ps
`default_nettype none
module bsw_pacer
    import bsw_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic       base_tick,
    input  wire logic [1:0] spacing,
    output logic            step
);

    // ======================================================================
    // Phase counter
    logic [1:0] phase;

    // Phase is frozen while stopped so a resume keeps its place
    assign step = run & base_tick & ~clear & (phase == spacing - 2'h1);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase <= 2'h0;
        end else if (clear) begin
            phase <= 2'h0;
        end else if (run && base_tick) begin
            phase <= step ? 2'h0 : phase + 2'h1;
        end
    end

endmodule : bsw_pacer
`default_nettype wire

// >>> logic/bsw_bcd_digit.sv
// One BCD decade counter with clear and wrap pulse
`timescale 1ns/1ps
`default_nettype none
module bsw_bcd_digit
    import bsw_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic       step,
    output logic [3:0]      value,
    output logic            wrap
);

    // ======================================================================
    // Decade count
    assign wrap = step & ~clear & (value == BSW_DIGIT_MAX);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            value <= BSW_DIGIT_RESET;
        end else if (clear) begin
            value <= BSW_DIGIT_RESET;
        end else if (step) begin
            value <= wrap ? BSW_DIGIT_RESET : value + 4'h1;
        end
    end

endmodule : bsw_bcd_digit
`default_nettype wire

// >>> logic/bsw_timer.sv
// Stopwatch timer top: APB registers, tick sync, digits, event flags
`timescale 1ns/1ps
`default_nettype none
module bsw_timer
    import bsw_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  base_256hz,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [BSW_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       tenth_second_irq,
    output logic                       one_second_irq
);

    // ======================================================================
    // Declarations
    logic        base_sync1;
    logic        base_sync2;
    logic        base_prev;
    logic        base_tick;
    logic        count_run_control;
    logic [1:0]  irq_enable;
    logic [1:0]  event_flag;
    logic [3:0]  hundredths_bcd_digit;
    logic [3:0]  tenths_bcd_digit;
    logic        hund_step;
    logic        hund_wrap;
    logic        tenth_wrap;
    logic [1:0]  spacing;
    logic        apb_fire;
    logic        wr_fire;
    logic        rd_phase;
    logic [15:0] reg_index;
    logic        addr_aligned;
    logic        hit_control;
    logic        hit_hund;
    logic        hit_tenth;
    logic        hit_en;
    logic        hit_flag;
    logic        addr_hit;
    logic        counter_clear_strobe;
    logic [1:0]  flag_clear;
    logic [31:0] next_prdata;

    // ======================================================================
    // Base tick synchroniser
    // Prescaler output comes from outside this clock; two flops first
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            base_sync1 <= 1'b0;
            base_sync2 <= 1'b0;
            base_prev  <= 1'b0;
        end else begin
            base_sync1 <= base_256hz;
            base_sync2 <= base_sync1;
            base_prev  <= base_sync2;
        end
    end

    assign base_tick = base_sync2 & ~base_prev;

    // ======================================================================
    // APB decode
    assign reg_index    = paddr[17:2];
    assign addr_aligned = (paddr[1:0] == 2'h0);
    assign hit_control  = addr_aligned & (reg_index == BSW_IDX_CONTROL);
    assign hit_hund     = addr_aligned & (reg_index == BSW_IDX_HUNDREDTH);
    assign hit_tenth    = addr_aligned & (reg_index == BSW_IDX_TENTH);
    assign hit_en       = addr_aligned & (reg_index == BSW_IDX_IRQ_EN);
    assign hit_flag     = addr_aligned & (reg_index == BSW_IDX_IRQ_FLAG);
    assign addr_hit     = hit_control | hit_hund | hit_tenth | hit_en | hit_flag;

    // One wait state: pready rises in the second access cycle
    assign rd_phase = psel & penable & ~pready;
    assign apb_fire = psel & penable & pready;
    assign wr_fire  = apb_fire & pwrite & addr_hit;

    assign counter_clear_strobe = wr_fire & hit_control & pwdata[BSW_BIT_CLEAR];
    assign flag_clear = (wr_fire & hit_flag) ? pwdata[1:0] : 2'h0;

    // ======================================================================
    // Read mux
    always_comb begin
        next_prdata = 32'h0;
        if (hit_control) begin
            // Clear bit is write-only, upper bits unimplemented
            next_prdata[BSW_BIT_RUN] = count_run_control;
        end else if (hit_hund) begin
            next_prdata[3:0] = hundredths_bcd_digit;
        end else if (hit_tenth) begin
            next_prdata[3:0] = tenths_bcd_digit;
        end else if (hit_en) begin
            next_prdata[1:0] = irq_enable;
        end else if (hit_flag) begin
            next_prdata[1:0] = event_flag;
        end
    end

    // ======================================================================
    // APB answer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= rd_phase;
            pslverr <= rd_phase & ~addr_hit;
            if (rd_phase && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    // ======================================================================
    // Run control and interrupt enables
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_run_control <= BSW_RUN_RESET;
        end else if (wr_fire && hit_control) begin
            count_run_control <= pwdata[BSW_BIT_RUN];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_enable <= BSW_EN_RESET;
        end else if (wr_fire && hit_en) begin
            irq_enable <= pwdata[1:0];
        end
    end

    // ======================================================================
    // Count chain
    // Extra long step at digit 8 in a long decade gives 26 ticks
    assign spacing = (hundredths_bcd_digit[0]
                      || (hundredths_bcd_digit == BSW_EXTRA_DIGIT
                          && BSW_LONG_DECADE[tenths_bcd_digit]))
                     ? BSW_LONG_STEP : BSW_SHORT_STEP;

    bsw_pacer u_pacer (
        .clock     (clock),
        .rst       (rst),
        .clear     (counter_clear_strobe),
        .run       (count_run_control),
        .base_tick (base_tick),
        .spacing   (spacing),
        .step      (hund_step)
    );

    bsw_bcd_digit u_hund (
        .clock (clock),
        .rst   (rst),
        .clear (counter_clear_strobe),
        .step  (hund_step),
        .value (hundredths_bcd_digit),
        .wrap  (hund_wrap)
    );

    bsw_bcd_digit u_tenth (
        .clock (clock),
        .rst   (rst),
        .clear (counter_clear_strobe),
        .step  (hund_wrap),
        .value (tenths_bcd_digit),
        .wrap  (tenth_wrap)
    );

    // ======================================================================
    // Event flags
    // Set beats a same-cycle clear so no overflow is lost
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_flag <= BSW_FLAG_RESET;
        end else begin
            event_flag[BSW_BIT_TENTH] <= hund_wrap
                | (event_flag[BSW_BIT_TENTH] & ~flag_clear[BSW_BIT_TENTH]);
            event_flag[BSW_BIT_ONE]   <= tenth_wrap
                | (event_flag[BSW_BIT_ONE] & ~flag_clear[BSW_BIT_ONE]);
        end
    end

    // ======================================================================
    // Interrupt requests
    // Level requests, one cycle behind the flag
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tenth_second_irq <= 1'b0;
            one_second_irq   <= 1'b0;
        end else begin
            tenth_second_irq <= event_flag[BSW_BIT_TENTH] & irq_enable[BSW_BIT_TENTH];
            one_second_irq   <= event_flag[BSW_BIT_ONE] & irq_enable[BSW_BIT_ONE];
        end
    end

    // ======================================================================
    // Assertions
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access_wait;
        psel && penable && !pready;
    endsequence

    property p_apb_answer;
        @(posedge clock) disable iff (rst)
        s_setup ##1 s_access_wait |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("pready late");

    property p_ctrl_read;
        @(posedge clock) disable iff (rst)
        (rd_phase && !pwrite && hit_control)
            |=> (prdata[31:1] == 31'h0) && (prdata[0] == count_run_control);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    property p_flag_read;
        @(posedge clock) disable iff (rst)
        (rd_phase && !pwrite && hit_flag) |=> (prdata[31:2] == 30'h0);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag upper bits set");

    property p_clear;
        @(posedge clock) disable iff (rst)
        counter_clear_strobe |=> (hundredths_bcd_digit == 4'h0) && (tenths_bcd_digit == 4'h0);
    endproperty
    a_clear: assert property (p_clear) else $error("digits not cleared");

    property p_digit_write_ignored;
        @(posedge clock) disable iff (rst)
        (wr_fire && (hit_hund || hit_tenth) && !hund_step)
            |=> $stable(hundredths_bcd_digit);
    endproperty
    a_digit_write_ignored: assert property (p_digit_write_ignored) else $error("digit written");

    property p_stopped_hold;
        @(posedge clock) disable iff (rst)
        (!count_run_control && !counter_clear_strobe)
            |=> $stable(hundredths_bcd_digit) && $stable(tenths_bcd_digit);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold) else $error("digits moved while stopped");

    property p_run_write;
        @(posedge clock) disable iff (rst)
        (wr_fire && hit_control) |=> (count_run_control == $past(pwdata[0]));
    endproperty
    a_run_write: assert property (p_run_write) else $error("run bit not loaded");

    property p_step_on_tick;
        @(posedge clock) disable iff (rst)
        hund_step |-> base_tick && count_run_control;
    endproperty
    a_step_on_tick: assert property (p_step_on_tick) else $error("step without tick");

    property p_bcd_range;
        @(posedge clock) disable iff (rst)
        (hundredths_bcd_digit <= 4'h9) && (tenths_bcd_digit <= 4'h9);
    endproperty
    a_bcd_range: assert property (p_bcd_range) else $error("digit out of range");

    property p_wrap_flag;
        @(posedge clock) disable iff (rst)
        hund_wrap |=> event_flag[0] && (hundredths_bcd_digit == 4'h0);
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("10 Hz flag missed");

    property p_carry;
        @(posedge clock) disable iff (rst)
        (hund_wrap && tenths_bcd_digit != 4'h9)
            |=> tenths_bcd_digit == $past(tenths_bcd_digit) + 4'h1;
    endproperty
    a_carry: assert property (p_carry) else $error("carry lost");

    property p_flag_sticky;
        @(posedge clock) disable iff (rst)
        (event_flag[1] && !flag_clear[1]) |=> event_flag[1];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("1 Hz flag dropped");

    property p_irq;
        @(posedge clock) disable iff (rst)
        (event_flag[0] && irq_enable[0]) |=> tenth_second_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("10 Hz request missing");

    property p_one_flag;
        @(posedge clock) disable iff (rst)
        tenth_wrap |=> event_flag[BSW_BIT_ONE];
    endproperty
    a_one_flag: assert property (p_one_flag) else $error("1 Hz flag missed");

    property p_flag_clear;
        @(posedge clock) disable iff (rst)
        (flag_clear[BSW_BIT_TENTH] && !hund_wrap) |=> !event_flag[BSW_BIT_TENTH];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("10 Hz flag not cleared");

    property p_bad_addr;
        @(posedge clock) disable iff (rst)
        (rd_phase && !addr_hit) |=> pready && pslverr;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not refused");

    property p_good_addr;
        @(posedge clock) disable iff (rst)
        (rd_phase && addr_hit) |=> pready && !pslverr;
    endproperty
    a_good_addr: assert property (p_good_addr) else $error("mapped access refused");

    property p_en_read;
        @(posedge clock) disable iff (rst)
        (rd_phase && !pwrite && hit_en) |=> (prdata == {30'h0, irq_enable});
    endproperty
    a_en_read: assert property (p_en_read) else $error("enable read wrong");

    property p_hund_read;
        @(posedge clock) disable iff (rst)
        (rd_phase && !pwrite && hit_hund) |=> (prdata == {28'h0, $past(hundredths_bcd_digit)});
    endproperty
    a_hund_read: assert property (p_hund_read) else $error("hundredths read wrong");

    property p_irq_off;
        @(posedge clock) disable iff (rst)
        !(event_flag[BSW_BIT_ONE] && irq_enable[BSW_BIT_ONE]) |=> !one_second_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("1 Hz request without cause");

    // Clear with run set must not stop the count
    sequence s_clear_run;
        counter_clear_strobe && pwdata[BSW_BIT_RUN];
    endsequence

    property p_clear_keeps_run;
        @(posedge clock) disable iff (rst)
        s_clear_run |=> count_run_control && (hundredths_bcd_digit == BSW_DIGIT_RESET);
    endproperty
    a_clear_keeps_run: assert property (p_clear_keeps_run) else $error("run lost on clear");

    property p_single_tick;
        @(posedge clock) disable iff (rst)
        base_tick |=> !base_tick;
    endproperty
    a_single_tick: assert property (p_single_tick) else $error("base tick longer than one cycle");

endmodule : bsw_timer
`default_nettype wire

// >>> bench/bsw_timer_test.sv
// Self-checking testbench for the stopwatch timer over APB
`timescale 1ns/1ps
`default_nettype none
module bsw_timer_test;
    import bsw_pkg::*;

    // ======================================================================
    // Addresses and bench state
    localparam logic [17:0] A_CTRL = {BSW_IDX_CONTROL, 2'b00};
    localparam logic [17:0] A_HUN  = {BSW_IDX_HUNDREDTH, 2'b00};
    localparam logic [17:0] A_TEN  = {BSW_IDX_TENTH, 2'b00};
    localparam logic [17:0] A_EN   = {BSW_IDX_IRQ_EN, 2'b00};
    localparam logic [17:0] A_FLAG = {BSW_IDX_IRQ_FLAG, 2'b00};
    localparam logic [17:0] A_BAD  = 18'h00010;

    logic        clock;
    logic        rst;
    logic        base_256hz;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tenth_second_irq;
    logic        one_second_irq;
    int          n_fail;
    int          checks;
    int          cycles;
    int          ph;
    logic [3:0]  eh;
    logic [3:0]  et;
    logic [1:0]  ef;
    logic [1:0]  een;
    logic        erun;
    logic [31:0] rdat;
    logic        rerr;

    bsw_timer bsw_timer_i (
        .clock            (clock),
        .rst              (rst),
        .base_256hz       (base_256hz),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .tenth_second_irq (tenth_second_irq),
        .one_second_irq   (one_second_irq)
    );

    always #10 clock = ~clock;

    task automatic test_done;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // Whole run needs about 5750 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end

    // ======================================================================
    // Compare and bus tasks
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: level %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic apb(input logic wr, input logic [17:0] addr, input logic [31:0] wd);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [17:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk_val(rdat, exp);
    endtask : rd_chk

    // Request level lags the flag and enable by a register stage
    task automatic chk_irq;
        repeat (2) @(posedge clock);
        chk_bit(tenth_second_irq, ef[0] & een[0]);
        chk_bit(one_second_irq, ef[1] & een[1]);
    endtask : chk_irq

    // Base ticks with a reference count model; digits read between ticks never tear
    task automatic tick(input int n);
        int sp;
        repeat (n) begin
            @(posedge clock);
            base_256hz <= 1'b1;
            repeat (4) @(posedge clock);
            base_256hz <= 1'b0;
            repeat (4) @(posedge clock);
            if (erun) begin
                ph++;
                sp = (eh[0] || (eh == 4'h8 && BSW_LONG_DECADE[et])) ? 3 : 2;
                if (ph == sp) begin
                    ph = 0;
                    if (eh == 4'h9) begin
                        eh = 4'h0;
                        ef[0] = 1'b1;
                        et = (et == 4'h9) ? 4'h0 : et + 4'h1;
                        ef[1] = ef[1] | (et == 4'h0);
                    end else begin
                        eh = eh + 4'h1;
                    end
                end
            end
            rd_chk(A_HUN, {28'h0, eh});
            rd_chk(A_TEN, {28'h0, et});
        end
    endtask : tick

    task automatic ctrl(input logic [31:0] v);
        apb(1'b1, A_CTRL, v);
        erun = v[0];
        if (v[1]) begin
            eh = 4'h0;
            et = 4'h0;
            ph = 0;
        end
    endtask : ctrl

    // ======================================================================
    // Test sequence
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        base_256hz = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0;
        pwdata = 32'h0;
        {n_fail, checks, cycles, ph} = '0;
        {eh, et, ef, een, erun} = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd_chk(A_CTRL, 32'h0);
        chk_bit(rerr, 1'b0);
        rd_chk(A_HUN, 32'h0);
        rd_chk(A_TEN, 32'h0);
        rd_chk(A_EN, 32'h0);
        rd_chk(A_FLAG, 32'h0);
        apb(1'b0, A_BAD, 32'h0);
        chk_bit(rerr, 1'b1);
        apb(1'b0, A_CTRL + 18'h1, 32'h0);
        chk_bit(rerr, 1'b1);
        $display("test reset done");
        apb(1'b1, A_HUN, 32'h5);
        rd_chk(A_HUN, 32'h0);
        apb(1'b1, A_TEN, 32'h7);
        rd_chk(A_TEN, 32'h0);
        apb(1'b1, A_EN, 32'hF);
        rd_chk(A_EN, 32'h3);
        apb(1'b1, A_EN, 32'h0);
        rd_chk(A_EN, 32'h0);
        ctrl(32'hE);
        rd_chk(A_CTRL, 32'h0);
        $display("test registers done");
        ctrl(32'h1);
        rd_chk(A_CTRL, 32'h1);
        tick(24);
        rd_chk(A_FLAG, 32'h0);
        tick(1);
        rd_chk(A_FLAG, 32'h1);
        tick(231);
        rd_chk(A_TEN, 32'h0);
        rd_chk(A_FLAG, 32'h3);
        chk_irq();
        $display("test count done");
        een = 2'h3;
        apb(1'b1, A_EN, 32'h3);
        chk_irq();
        apb(1'b1, A_FLAG, 32'h0);
        rd_chk(A_FLAG, 32'h3);
        apb(1'b1, A_FLAG, 32'h1);
        ef = 2'h2;
        rd_chk(A_FLAG, 32'h2);
        chk_irq();
        apb(1'b1, A_FLAG, 32'hE);
        ef = 2'h0;
        rd_chk(A_FLAG, 32'h0);
        chk_irq();
        $display("test interrupts done");
        tick(5);
        ctrl(32'h0);
        rd_chk(A_HUN, {28'h0, eh});
        rd_chk(A_TEN, {28'h0, et});
        tick(6);
        ctrl(32'h1);
        tick(7);
        ctrl(32'h0);
        ctrl(32'h2);
        tick(4);
        ctrl(32'h1);
        tick(20);
        ctrl(32'h3);
        tick(30);
        rd_chk(A_FLAG, {30'h0, ef});
        chk_irq();
        $display("test run control done");
        test_done();
    end

endmodule : bsw_timer_test
`default_nettype wire
